// >>> rtl/cci_pkg.sv
// Package for the comparator change interrupt block
package cci_pkg;
	// Number of independent comparator instances
	localparam int NUM_CMP = 2;
	// Instruction cycle phase encoding (four phases per cycle)
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} cci_phase_type;
	// Reset values
	localparam logic [1:0] PHASE_RST = 2'h0;
	localparam logic       LATCH_RST = 1'h0;
	localparam logic       FLAG_RST  = 1'h0;
	// Per-instance software access strobes
	typedef struct packed {
		logic ctrl_access;
		logic flag_wr;
		logic flag_wdata;
	} cci_sw_type;
	// Per-instance configuration bits: enables and output invert
	typedef struct packed {
		logic on;
		logic invert;
		logic irq_en;
	} cci_cfg_type;
endpackage

// >>> rtl/cci_top.sv
// Comparator change-detect interrupt logic for two comparators
`timescale 1ns/1ps
`default_nettype none
module cci_top (
	// Clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_reset_n,
	// Analog comparator raw outputs
	input  wire logic [cci_pkg::NUM_CMP-1:0] i_cmp_raw,
	// Software access strobes and configuration
	input  wire cci_pkg::cci_sw_type      i_sw [cci_pkg::NUM_CMP],
	input  wire cci_pkg::cci_cfg_type     i_cfg [cci_pkg::NUM_CMP],
	input  wire logic                     i_periph_low_enable,
	input  wire logic                     i_global_high_enable,
	// Status and interrupt outputs
	output var  logic [cci_pkg::NUM_CMP-1:0] o_comparator_result,
	output var  logic [cci_pkg::NUM_CMP-1:0] o_comparator_irq_flag,
	output var  logic [cci_pkg::NUM_CMP-1:0] o_mismatch,
	output var  logic                     o_irq_req
);
	// Reset synchroniser
	logic                            rst_s1_r;
	logic                            rst_n_r;

	// Instruction cycle phase and its decoded edges
	cci_pkg::cci_phase_type          phase_r;
	logic                            q1_edge;
	logic                            q3_edge;

	// Comparator input synchroniser
	logic [cci_pkg::NUM_CMP-1:0]     raw_s1_r;
	logic [cci_pkg::NUM_CMP-1:0]     raw_s2_r;

	// Level seen by both latches
	logic [cci_pkg::NUM_CMP-1:0]     result;

	// Mismatch latches and edge detector
	logic [cci_pkg::NUM_CMP-1:0]     access_pend_r;
	logic [cci_pkg::NUM_CMP-1:0]     refresh;
	logic [cci_pkg::NUM_CMP-1:0]     latch1_r;
	logic [cci_pkg::NUM_CMP-1:0]     latch2_r;
	logic [cci_pkg::NUM_CMP-1:0]     mism;
	logic [cci_pkg::NUM_CMP-1:0]     mism_d_r;
	logic [cci_pkg::NUM_CMP-1:0]     mism_rise;

	// Interrupt flag and request
	logic [cci_pkg::NUM_CMP-1:0]     flag_r;
	logic [cci_pkg::NUM_CMP-1:0]     req_en;
	logic                            any_req;
	logic                            global_en;

	// Phase decode, used by both latches
	function automatic logic phase_is(
		input cci_pkg::cci_phase_type ph,
		input cci_pkg::cci_phase_type want
	);
		return ph == want;
	endfunction

	// Level one comparator presents to its latches
	function automatic logic eff_level(
		input logic on,
		input logic invert,
		input logic raw
	);
		if (on) begin
			return raw ^ invert;
		end
		return invert;
	endfunction

	// Next phase of the four-phase instruction cycle
	function automatic cci_pkg::cci_phase_type phase_next(
		input cci_pkg::cci_phase_type ph
	);
		cci_pkg::cci_phase_type nxt;
		nxt = ph;
		unique case (ph)
			cci_pkg::PH_Q1: nxt = cci_pkg::PH_Q2;
			cci_pkg::PH_Q2: nxt = cci_pkg::PH_Q3;
			cci_pkg::PH_Q3: nxt = cci_pkg::PH_Q4;
			cci_pkg::PH_Q4: nxt = cci_pkg::PH_Q1;
		endcase
		return nxt;
	endfunction

	// Rising edge of a level sampled one clock apart
	function automatic logic rising(
		input logic cur,
		input logic prev
	);
		return cur && !prev;
	endfunction

	// Hardware set beats a software write in the same cycle
	function automatic logic flag_next(
		input logic                cur,
		input logic                rise,
		input cci_pkg::cci_sw_type sw
	);
		if (rise) begin
			return 1'h1;
		end
		if (sw.flag_wr) begin
			return sw.flag_wdata;
		end
		return cur;
	endfunction

	// Reset release through two flops
	// Assertion stays asynchronous; only release is timed
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_r <= 1'h0;
			rst_n_r  <= 1'h0;
		end else begin
			rst_s1_r <= 1'h1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// Four-phase instruction cycle counter
	// Free-running; software accesses are not aligned to it
	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			phase_r <= cci_pkg::cci_phase_type'(cci_pkg::PHASE_RST);
		end else begin
			phase_r <= phase_next(phase_r);
		end
	end

	// Both latches key off the phase ending at this edge
	assign q1_edge = phase_is(phase_r, cci_pkg::PH_Q1);
	assign q3_edge = phase_is(phase_r, cci_pkg::PH_Q3);

	// Analog output is asynchronous to the clock
	// Costs two cycles of latency on every change
	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			raw_s1_r <= '0;
			raw_s2_r <= '0;
		end else begin
			raw_s1_r <= i_cmp_raw;
			raw_s2_r <= raw_s1_r;
		end
	end

	// Instances share only clock, reset and phase
	genvar g;

	// Off: level follows invert bit so latches can be preset
	// Pin drive enable never enters here
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_level
			assign result[g] = eff_level(i_cfg[g].on, i_cfg[g].invert,
				raw_s2_r[g]);
		end
	endgenerate

	// Access strobe may come in any phase; held until Q3
	// Several strobes before one Q3 collapse into one refresh
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_pend
			always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
				if (!rst_n_r) begin
					access_pend_r[g] <= 1'h0;
				end else if (q3_edge) begin
					access_pend_r[g] <= 1'h0;
				end else if (i_sw[g].ctrl_access) begin
					access_pend_r[g] <= 1'h1;
				end
			end
			assign refresh[g] = q3_edge &&
				(access_pend_r[g] || i_sw[g].ctrl_access);
		end
	endgenerate

	// Reads and writes both refresh
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_latch1
			always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
				if (!rst_n_r) begin
					latch1_r[g] <= cci_pkg::LATCH_RST;
				end else if (refresh[g]) begin
					latch1_r[g] <= result[g];
				end
			end
		end
	endgenerate

	// Second latch follows the level once per instruction cycle
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_latch2
			always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
				if (!rst_n_r) begin
					latch2_r[g] <= cci_pkg::LATCH_RST;
				end else if (q1_edge) begin
					latch2_r[g] <= result[g];
				end
			end
		end
	endgenerate

	// Delayed copy resets low, as does the mismatch itself
	// so no false edge follows reset
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_edge
			assign mism[g] = latch1_r[g] ^ latch2_r[g];
			assign mism_rise[g] = rising(mism[g], mism_d_r[g]);
			always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
				if (!rst_n_r) begin
					mism_d_r[g] <= 1'h0;
				end else begin
					mism_d_r[g] <= mism[g];
				end
			end
		end
	endgenerate

	// Edge, not level, sets the flag; set beats software clear
	// A mismatch cleared by a Q3 refresh has already set the flag
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_flag
			always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
				if (!rst_n_r) begin
					flag_r[g] <= cci_pkg::FLAG_RST;
				end else begin
					flag_r[g] <= flag_next(flag_r[g], mism_rise[g], i_sw[g]);
				end
			end
		end
	endgenerate

	// Per-instance enable gates only the request
	// Flag itself never waits on any enable
	generate
		for (g = 0; g < cci_pkg::NUM_CMP; g++) begin : g_req
			assign req_en[g] = flag_r[g] && i_cfg[g].irq_en;
		end
	endgenerate

	// Registered level output
	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_comparator_result <= '0;
		end else begin
			o_comparator_result <= result;
		end
	end

	// Registered flag output
	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_comparator_irq_flag <= '0;
		end else begin
			o_comparator_irq_flag <= flag_r;
		end
	end

	// Registered mismatch output
	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_mismatch <= '0;
		end else begin
			o_mismatch <= mism;
		end
	end

	// Both global enables must be set for a request
	assign any_req   = |req_en;
	assign global_en = i_periph_low_enable && i_global_high_enable;

	// Flag stays set regardless of enables; only request is gated
	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_irq_req <= 1'h0;
		end else begin
			o_irq_req <= any_req &&
				global_en;
		end
	end
endmodule
`default_nettype wire

// >>> tb/cci_cmp_model.sv
// Analog comparator output model
`timescale 1ns/1ps
`default_nettype none
module cci_cmp_model (
	// Asked level and comparator output
	input  wire logic [1:0] i_level,
	output wire logic [1:0] o_raw
);
	// Lag keeps changes off the access edge
	assign #7 o_raw = i_level;
endmodule
`default_nettype wire

// >>> tb/cci_checker.sv
// Port checker for the change interrupt block
`timescale 1ns/1ps
`default_nettype none
module cci_checker (
	// Block ports
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [1:0] i_cmp_raw,
	input wire cci_pkg::cci_sw_type i_sw [cci_pkg::NUM_CMP],
	input wire cci_pkg::cci_cfg_type i_cfg [cci_pkg::NUM_CMP],
	input wire logic i_periph_low_enable,
	input wire logic i_global_high_enable,
	input wire logic [1:0] o_comparator_result,
	input wire logic [1:0] o_comparator_irq_flag,
	input wire logic [1:0] o_mismatch,
	input wire logic o_irq_req
);
	wire logic [1:0] f = o_comparator_irq_flag;
	wire logic [1:0] m = o_mismatch;
	wire logic [1:0] r = o_comparator_result;
	wire logic en = i_periph_low_enable & i_global_high_enable;
	wire logic clr = i_sw[0].flag_wr & ~i_sw[0].flag_wdata;
	wire logic set = i_sw[0].flag_wr & i_sw[0].flag_wdata;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	a_flag_on_rise: assert property (
		$rose(m[0]) |-> ##[0:2] f[0]) else $error("flag missed");
	a_flag_sticky: assert property (
		$fell(f[0]) |-> $past(clr, 1) || $past(clr, 2) || $past(clr, 3))
		else $error("flag lost");
	a_flag_sw_set: assert property (
		set |-> ##[1:3] f[0]) else $error("flag write ignored");
	a_mism_refresh: assert property (
		i_sw[0].ctrl_access ##1 $stable(r[0])[*8] |-> !m[0])
		else $error("mismatch kept");
	a_irq_gated: assert property (
		o_irq_req |-> $past(en, 1) || $past(en, 2)) else $error("irq ungated");
	a_irq_raised: assert property (
		(f[0] && i_cfg[0].irq_en && en)[*3] |-> o_irq_req) else $error("no irq");
	a_off_level: assert property (
		(!i_cfg[0].on && $stable(i_cfg[0].invert))[*5]
		|-> r[0] == i_cfg[0].invert) else $error("off level");
	a_on_level: assert property (
		(i_cfg[0].on && $stable({i_cmp_raw[0], i_cfg[0].invert}))[*5]
		|-> r[0] == (i_cmp_raw[0] ^ i_cfg[0].invert)) else $error("bad result");
	a_inst_apart: assert property (
		$rose(m[1]) |-> ##[0:2] f[1]) else $error("flag1 missed");
endmodule
bind cci_top cci_checker u_cci_checker (.i_clk_sys, .i_reset_n, .i_cmp_raw,
	.i_sw, .i_cfg, .i_periph_low_enable, .i_global_high_enable,
	.o_comparator_result, .o_comparator_irq_flag, .o_mismatch, .o_irq_req);
`default_nettype wire

// >>> tb/cci_top_tb_top.sv
// Self-checking bench for the change interrupt block
`timescale 1ns/1ps
`default_nettype none
module cci_top_tb_top;
	logic clk = 0, rst_n = 0, pe = 0, ge = 0, irq;
	logic [1:0] lvl = 0, cur = 0, res, flg, mis;
	logic [3:0] rn;
	wire logic [1:0] raw;
	cci_pkg::cci_sw_type sw [2] = '{default: '0};
	cci_pkg::cci_cfg_type cfg [2] = '{default: '0};
	int failures = 0, checks = 0;
	always #10 clk = ~clk;
	cci_cmp_model u_cci_cmp_model (.i_level(lvl), .o_raw(raw));
	cci_top u_cci_top (.i_clk_sys(clk), .i_reset_n(rst_n), .i_cmp_raw(raw),
		.i_sw(sw), .i_cfg(cfg), .i_periph_low_enable(pe),
		.i_global_high_enable(ge), .o_comparator_result(res),
		.o_comparator_irq_flag(flg), .o_mismatch(mis), .o_irq_req(irq));
	function automatic logic [1:0] flip(input logic [1:0] a, b);
		return a ^ b;
	endfunction
	task chk(input logic [1:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %b want %b", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Idle cycle after release avoids a double drive
	task put(input logic [1:0] a, w, input logic d);
		sw <= '{'{a[0], w[0], d}, '{a[1], w[1], d}};
		cyc(1);
		sw <= '{default: '0};
		cyc(1);
	endtask
	initial begin
		void'($urandom(3));
		cyc(10);
		rst_n <= 1;
		cyc(4);
		cfg <= '{2{3'b010}};
		cyc(6);
		chk(res, 3);
		cfg <= '{2{3'b000}};
		cyc(6);
		put(3, 0, 0);
		put(0, 3, 0);
		cfg <= '{2{3'b101}};
		cyc(50);
		put(3, 0, 0);
		put(0, 3, 0);
		cyc(8);
		chk(mis | flg, 0);
		$display("preset done");
		pe <= 1;
		ge <= 1;
		lvl <= 1;
		cyc(12);
		chk(flg, 1);
		chk(mis, 1);
		chk({1'b0, irq}, 1);
		pe <= 0;
		put(0, 1, 0);
		cyc(4);
		chk(flg, 0);
		chk(mis, 1);
		lvl <= 0;
		cyc(12);
		chk(mis | flg, 0);
		lvl <= 1;
		cyc(12);
		chk(flg, 1);
		chk({1'b0, irq}, 0);
		put(0, 1, 0);
		put(1, 0, 0);
		cyc(8);
		chk(mis, 0);
		lvl <= 0;
		cyc(12);
		put(0, 2, 1);
		cyc(4);
		chk(flg, 3);
		$display("edge tests done");
		repeat (20) begin
			rn = 4'($urandom);
			cfg <= '{'{1'b1, rn[2], 1'b1}, '{1'b1, rn[3], 1'b1}};
			cyc(8);
			put(3, 0, 0);
			cyc(8);
			put(0, 3, 0);
			lvl <= rn[1:0];
			cyc(12);
			chk(flg, flip(cur, rn[1:0]));
			cur = rn[1:0];
		end
		$display("random done");
		test_done;
	end
	initial begin
		cyc(3000);
		failures++;
		test_done;
	end
endmodule
`default_nettype wire
